// >>> rtl/led_sink_pkg.sv
// Package: constants and types for the twelve-stage LED sink driver
package led_sink_pkg;
  localparam int STAGES = 12;
  localparam int RISE_TAP = 10;
  localparam int FALL_TAP = 11;
  localparam int BUF_DEPTH = 2;
  localparam logic [STAGES-1:0] CHAIN_RST = 12'h000;
  localparam logic [STAGES-1:0] LATCH_RST = 12'h000;
  localparam logic SERIAL_RST = 1'b0;
  localparam logic CLK_RST = 1'b0;
  // Event kinds carried through the buffer
  typedef enum logic {EV_RISE, EV_FALL} edge_kind_e;
  typedef struct packed {
    edge_kind_e kind;
    logic bit_in;
  } edge_event_s;
endpackage

// >>> rtl/edge_stream_if.sv
// Interface: valid/ready stream of shift clock events
`timescale 1ns/10ps
`default_nettype none
interface edge_stream_if;
  import led_sink_pkg::*;
  logic valid;
  logic ready;
  edge_event_s data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> rtl/edge_buffer.sv
// Module: two-entry buffer for shift clock events
`timescale 1ns/10ps
`default_nettype none
module edge_buffer
#(
  parameter int DEPTH = led_sink_pkg::BUF_DEPTH
)
(
  input wire logic clk,
  input wire logic rst,
  edge_stream_if.dst in_s,
  edge_stream_if.src out_s
);
  import led_sink_pkg::*;
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  edge_event_s mem_q [DEPTH];
  edge_event_s mem_d [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == LAST) ? '0 : p + 1'b1;
  endfunction

  assign in_s.ready = (cnt_q != CW'(DEPTH));
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data = mem_q[rd_q];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
      mem_d[i] = mem_q[i];
    if (push)
      mem_d[wr_q] = in_s.data;
    wr_d = push ? bump(wr_q) : wr_q;
    rd_d = pop ? bump(rd_q) : rd_q;
    cnt_d = cnt_q + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
    for (int i = 0; i < DEPTH; i++)
      mem_q[i] <= mem_d[i];
  end
endmodule // edge_buffer
`default_nettype wire

// >>> rtl/led_sink_driver.sv
// Module: twelve-stage shift-and-store LED sink driver
// Function
// [R1] Twelve stages, serial input into stage zero
// [R2] Shift only on shift clock rising edges
// [R3] Strobe high: latches follow; low: hold
// [R4] Enable low floats all parallel outputs
// [R5] Stored one sinks low, zero floats
// [R6] Rise output takes stage ten on rise
// [R7] Fall output takes stage eleven on fall
// [R8] Cascade from rise or fall output
// [R9] Host shifts bits, then pulses strobe
// [R10] Keep enable low until pattern loaded
`timescale 1ns/10ps
`default_nettype none
module led_sink_driver
#(
  parameter int STAGES = led_sink_pkg::STAGES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_in,
  input wire logic shift_clock,
  input wire logic latch_strobe,
  input wire logic output_enable,
  input wire logic drain_stall,
  output logic shift_ready,
  output logic [STAGES-1:0] led_sink_out,
  output logic [STAGES-1:0] led_sink_oe,
  output logic cascade_out_rise,
  output logic cascade_out_fall
);
  import led_sink_pkg::*;

  // ==========================================================
  // Edge detection on the sampled shift clock
  logic clk_prev_q, clk_prev_d;
  edge_stream_if ev_in ();
  edge_stream_if ev_out ();

  always_comb
  begin
    clk_prev_d = shift_clock;
    ev_in.valid = (shift_clock != clk_prev_q);
    ev_in.data.kind = shift_clock ? EV_RISE : EV_FALL;
    ev_in.data.bit_in = serial_in;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      clk_prev_q <= CLK_RST;
    else
      clk_prev_q <= clk_prev_d;
  end

  // ==========================================================
  // Event buffer
  // Events keep their order, so a fall sees the chain as it stood after
  // every earlier rise the buffer accepted; edges that arrive while it is full are lost
  edge_buffer #(.DEPTH(BUF_DEPTH)) u_buf
  (
    .clk(clk),
    .rst(rst),
    .in_s(ev_in),
    .out_s(ev_out)
  );

  assign ev_out.ready = !drain_stall;

  // ==========================================================
  // Shift chain and serial outputs
  logic [STAGES-1:0] chain_q, chain_d;
  logic rise_q, rise_d, fall_q, fall_d;
  logic take_rise, take_fall;

  // Head of the buffer is consumed this cycle and is of kind want
  function automatic logic head_is(input logic v, input logic r,
                                   input edge_kind_e got,
                                   input edge_kind_e want);
    head_is = v && r && (got == want);
  endfunction

  assign take_rise = head_is(ev_out.valid, ev_out.ready,
                             ev_out.data.kind, EV_RISE);
  assign take_fall = head_is(ev_out.valid, ev_out.ready,
                             ev_out.data.kind, EV_FALL);

  // One slice per stage; stage zero alone listens to the serial input
  for (genvar s = 0; s < STAGES; s++)
  begin : g_stage
    if (s == 0)
    begin : g_head
      assign chain_d[s] = take_rise ? ev_out.data.bit_in // [R1] [R2]
                                    : chain_q[s];
    end
    else
    begin : g_body
      assign chain_d[s] = take_rise ? chain_q[s-1] // [R1] [R2]
                                    : chain_q[s];
    end
  end

  always_comb
  begin
    rise_d = rise_q;
    fall_d = fall_q;
    // Taps read the chain as it stood before this event
    if (take_rise)
      rise_d = chain_q[RISE_TAP]; // [R6]
    if (take_fall)
      fall_d = chain_q[FALL_TAP]; // [R7]
  end

  // ==========================================================
  // Storage latches and open-drain drive
  logic [STAGES-1:0] latch_q, latch_d;
  logic [STAGES-1:0] oe_q, oe_d;
  logic [STAGES-1:0] low_q, low_d;

  always_comb
  begin
    // Registered transparency: the latch trails the chain by a cycle
    latch_d = latch_strobe ? chain_q : latch_q; // [R3]
  end

  // ==========================================================
  // Per-pin open-drain stage
  // The data value never changes, so a pin can only sink or float;
  // driving high into an LED string would fight its supply
  for (genvar p = 0; p < STAGES; p++)
  begin : g_pin
    assign oe_d[p] = output_enable && latch_q[p]; // [R4] [R5]
    assign low_d[p] = 1'b0; // [R5]
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // Parts without reset power up random; here a known zero
      chain_q <= CHAIN_RST; // [R10]
      latch_q <= LATCH_RST; // [R10]
      oe_q <= '0;
      low_q <= '0;
      rise_q <= SERIAL_RST;
      fall_q <= SERIAL_RST;
      shift_ready <= 1'b1;
    end
    else
    begin
      chain_q <= chain_d;
      latch_q <= latch_d;
      oe_q <= oe_d;
      low_q <= low_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      shift_ready <= ev_in.ready;
    end
  end

  assign led_sink_oe = oe_q;
  // Both cascade taps are offered; the far side picks one
  assign cascade_out_rise = rise_q; // [R8]
  assign cascade_out_fall = fall_q; // [R8]
  assign led_sink_out = low_q;
endmodule // led_sink_driver
`default_nettype wire

// >>> tb/led_sink_checker.sv
// Port assertions of the LED sink driver
`timescale 1ns/10ps
`default_nettype none
module led_sink_checker
#(parameter int STAGES = 12)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic shift_clock,
  input wire logic latch_strobe,
  input wire logic output_enable,
  input wire logic drain_stall,
  input wire logic shift_ready,
  input wire logic [STAGES-1:0] led_sink_out,
  input wire logic [STAGES-1:0] led_sink_oe,
  input wire logic cascade_out_rise,
  input wire logic cascade_out_fall
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ====
  // Pin rules
  rst_clear_a: assert property (disable iff (1'b0)
    rst |=> !led_sink_oe && !cascade_out_fall && shift_ready) else $error("rst");
  sink_low_a: assert property (led_sink_out == '0)
    else $error("pin driven high");
  float_off_a: assert property (!output_enable |=> !led_sink_oe)
    else $error("pin sinks while disabled");
  oe_cause_a: assert property ($changed(led_sink_oe) |->
    $past(latch_strobe, 2) || $past(output_enable) != $past(output_enable, 2))
    else $error("latch moved without strobe");
  fall_copy_a: assert property ($changed(cascade_out_fall) |->
    cascade_out_fall == $past(cascade_out_rise)) else $error("fall output");
  rise_edge_a: assert property ($changed(cascade_out_rise) |->
    $past(shift_clock)) else $error("rise output off edge");
  ready_back_a: assert property (!drain_stall [*4] |-> shift_ready)
    else $error("ready stuck low");
  full_cause_a: assert property (!shift_ready |-> $past(drain_stall) ||
    $past(drain_stall, 2)) else $error("ready low without stall");
  cover property (!shift_ready);
  cover property ($changed(cascade_out_fall));
  cover property ($fell(output_enable) ##3 !led_sink_oe);
endmodule // led_sink_checker
bind led_sink_driver led_sink_checker #(.STAGES(STAGES)) chk_u (.*);
`default_nettype wire

// >>> tb/host_model.sv
// Host model: shifts words in and pulses the strobe
`timescale 1ns/10ps
`default_nettype none
module host_model
(
  input wire logic clk,
  output var logic serial_in = 1'b0,
  output var logic shift_clock = 1'b0,
  output var logic latch_strobe = 1'b0
);
  // ====
  // Far bit first, so bit 11 ends in stage 11
  task automatic send(input logic [11:0] w, input logic s);
    for (int i = 11; i >= 0; i--)
    begin
      @(posedge clk);
      serial_in <= w[i];
      shift_clock <= 1'b1;
      repeat (2) @(posedge clk);
      shift_clock <= 1'b0;
      // Data is stale once the rise is over
      serial_in <= ~w[i];
      repeat (2) @(posedge clk);
    end
    latch_strobe <= s;
    repeat (3) @(posedge clk);
    latch_strobe <= 1'b0;
  endtask
endmodule // host_model
`default_nettype wire

// >>> tb/led_sink_driver_bench.sv
// Directed bench for the LED sink driver
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t mismatch", $time); end end
module led_sink_driver_bench;
  import led_sink_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic output_enable = 1'b0;
  logic drain_stall = 1'b0;
  wire logic serial_in, shift_clock, latch_strobe, shift_ready;
  wire logic cascade_out_rise, cascade_out_fall;
  wire logic [STAGES-1:0] led_sink_out, led_sink_oe;
  int fails = 0;
  int num_checks = 0;
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  host_model host_u (.*);
  led_sink_driver dut_u (.*);
  // ====
  // Scenarios
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic test_stall();
    drain_stall <= 1'b1;
    host_u.send(12'h000, 1'b0);
    `CHK(shift_ready, 1'b0)
    drain_stall <= 1'b0;
    wait_n(4);
    `CHK(shift_ready, 1'b1)
    $display("stall done");
  endtask
  task automatic test_load();
    host_u.send(12'hA5C, 1'b1);
    output_enable <= 1'b1;
    wait_n(3);
    `CHK(led_sink_oe, 12'hA5C)
    `CHK(led_sink_out, 12'h000)
    `CHK(cascade_out_rise, 1'b1)
    `CHK(cascade_out_fall, 1'b1)
    $display("load done");
  endtask
  task automatic test_hold();
    host_u.send(12'h3F0, 1'b0);
    wait_n(3);
    `CHK(led_sink_oe, 12'hA5C)
    `CHK(cascade_out_fall, 1'b0)
    output_enable <= 1'b0;
    host_u.send(12'h3F0, 1'b1);
    `CHK(led_sink_oe, 12'h000)
    output_enable <= 1'b1;
    wait_n(3);
    `CHK(led_sink_oe, 12'h3F0)
    $display("hold done");
  endtask
  task automatic test_reset();
    rst <= 1'b1;
    wait_n(2);
    rst <= 1'b0;
    wait_n(1);
    `CHK(led_sink_oe, 12'h000)
    `CHK(shift_ready, 1'b1)
    $display("reset done");
  endtask
  initial
  begin
    wait_n(3);
    rst <= 1'b0;
    test_stall();
    test_load();
    test_hold();
    test_reset();
    end_sim();
  end
  // About 270 cycles of work; this leaves wide margin
  initial
  begin
    #5000;
    fails++;
    end_sim();
  end
endmodule // led_sink_driver_bench
`default_nettype wire
